// File: design/rfx_params.svh
// constants for the return-flow instruction executor
`ifndef RFX_PARAMS_SVH
`define RFX_PARAMS_SVH
`define OP_IRQ_RETURN     14'h0009
`define OP_SUB_RETURN     14'h0008
`define OP_IDLE_MASK      14'h3F9F
`define OP_IDLE_VALUE     14'h0000
`define OP_LIT_MASK       14'h3C00
`define OP_LIT_VALUE      14'h3400
`define PC_RESET          13'h0000
`define ACC_RESET         8'h00
`define IRQ_ENABLE_RESET  1'h0
`endif

// File: design/rfx_pkg.sv
// types for the return-flow instruction executor
package rfx_pkg;
    typedef enum logic [2:0] {
        OPK_NONE,
        OPK_IDLE,
        OPK_IRQ_RET,
        OPK_LIT_RET,
        OPK_SUB_RET
    } op_kind_t;
endpackage : rfx_pkg

// File: design/rfx_decode.sv
// opcode classifier for the return-flow instructions
`timescale 1ns/1ns
`include "rfx_params.svh"
module rfx_decode (
    input  wire logic [13:0]       opcode,
    output rfx_pkg::op_kind_t      kind
);
    import rfx_pkg::*;
    // classify; don't-care bits are masked off
    always_comb begin
        if (opcode == `OP_IRQ_RETURN) begin
            kind = OPK_IRQ_RET;
        end else if (opcode == `OP_SUB_RETURN) begin
            kind = OPK_SUB_RET;
        end else if ((opcode & `OP_LIT_MASK) == `OP_LIT_VALUE) begin
            kind = OPK_LIT_RET;
        end else if ((opcode & `OP_IDLE_MASK) == `OP_IDLE_VALUE) begin
            kind = OPK_IDLE;
        end else begin
            kind = OPK_NONE;
        end
    end
endmodule : rfx_decode

// File: design/return_flow_instr_exec.sv
// execution of the return, interrupt-return, literal-return and idle instructions
`timescale 1ns/1ns
`include "rfx_params.svh"
module return_flow_instr_exec (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        instr_valid,
    input  wire logic [13:0] instr_word,
    input  wire logic [12:0] stack_top_entry,
    input  wire logic        irq_enable_clear,
    output logic             instr_ready,
    output logic             stack_pop,
    output logic [12:0]      pc,
    output logic             pc_load,
    output logic [7:0]       acc,
    output logic             global_irq_enable,
    output logic             instr_done,
    output logic             instr_unknown
);
    import rfx_pkg::*;

    // ----------------------------------------
    // local types
    // ----------------------------------------
    // a two-cycle instruction spends its second (flush) cycle in ST_SECOND
    typedef enum {ST_IDLE, ST_SECOND} state_t;

    // ----------------------------------------
    // registers and next values
    // ----------------------------------------
    // sequencing group
    state_t      state;
    state_t      next_state;
    logic        next_ready;
    logic        next_done;
    logic        next_unknown;
    // program counter group
    logic [12:0] next_pc;
    logic        next_pc_load;
    logic        next_pop;
    // accumulator group
    logic [7:0]  next_acc;
    // interrupt enable group
    logic        next_irq_enable;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    op_kind_t kind;

    // classify the offered word; the result is only used while it is taken
    rfx_decode u_decode (
        .opcode (instr_word),
        .kind   (kind)
    );

    // ----------------------------------------
    // acceptance
    // ----------------------------------------
    logic take;
    logic take_idle;
    logic take_irq_ret;
    logic take_lit_ret;
    logic take_sub_ret;
    logic take_unknown;
    logic take_return;

    // a word is taken only in ST_IDLE with ready high; during the flush
    // cycle ready is low and whatever is offered is refused
    always_comb begin
        take         = instr_valid && instr_ready && (state == ST_IDLE);
        take_idle    = take && (kind == OPK_IDLE);
        take_irq_ret = take && (kind == OPK_IRQ_RET);
        take_lit_ret = take && (kind == OPK_LIT_RET);
        take_sub_ret = take && (kind == OPK_SUB_RET);
        take_unknown = take && (kind == OPK_NONE);
        take_return  = take_irq_ret || take_lit_ret || take_sub_ret;
    end

    // ----------------------------------------
    // timing of one return, edge by edge
    // ----------------------------------------
    // edge 0: word taken, ST_IDLE to ST_SECOND
    // after edge 0: pc, acc or enable updated, pc_load and stack_pop high,
    //               ready low
    // after edge 1: instr_done high, ready high again, pulses low
    // edge 2: the next word may be taken

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    // all three returns take two cycles: the pop and load land after the
    // taking edge, completion is reported one edge later; idle completes
    // after the taking edge and never drops ready
    always_comb begin
        next_state   = state;
        next_ready   = 1'h1;
        next_done    = 1'h0;
        next_unknown = 1'h0;
        case (state)
            ST_IDLE: begin
                if (take_return) begin
                    next_ready = 1'h0;
                    next_state = ST_SECOND;
                end else if (take_idle) begin
                    next_done = 1'h1;
                end else if (take_unknown) begin
                    next_unknown = 1'h1; // foreign opcode: flag only
                end
            end
            ST_SECOND: begin
                next_done  = 1'h1;
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // register the sequencing group
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state         <= ST_IDLE;
            instr_ready   <= 1'h1;
            instr_done    <= 1'h0;
            instr_unknown <= 1'h0;
        end else begin
            state         <= next_state;
            instr_ready   <= next_ready;
            instr_done    <= next_done;
            instr_unknown <= next_unknown;
        end
    end

    // ----------------------------------------
    // program counter and stack pop
    // ----------------------------------------
    // every return loads the stack top and pops it in the same cycle; the
    // stack side must present the entry before the taking edge, since no
    // wait is inserted for it
    always_comb begin
        next_pc      = pc;
        next_pc_load = 1'h0;
        next_pop     = 1'h0;
        if (take_return) begin
            next_pc      = stack_top_entry;
            next_pc_load = 1'h1;
            next_pop     = 1'h1;
        end
    end

    // register the program counter group
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pc        <= `PC_RESET;
            pc_load   <= 1'h0;
            stack_pop <= 1'h0;
        end else begin
            pc        <= next_pc;
            pc_load   <= next_pc_load;
            stack_pop <= next_pop;
        end
    end

    // ----------------------------------------
    // accumulator
    // ----------------------------------------
    // only the literal return writes it; the low byte of the word is the
    // literal, bits 13:10 are opcode and bits 9:8 are ignored
    always_comb begin
        next_acc = acc;
        if (take_lit_ret) begin
            next_acc = instr_word[7:0];
        end
    end

    // register the accumulator
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc <= `ACC_RESET;
        end else begin
            acc <= next_acc;
        end
    end

    // ----------------------------------------
    // global interrupt enable
    // ----------------------------------------
    // the clear request comes from the interrupt-entry logic elsewhere in
    // the core; when it meets an interrupt return in the same cycle the
    // set wins, so a clear in its taking cycle never leaves an interrupt return masked
    always_comb begin
        next_irq_enable = global_irq_enable;
        if (irq_enable_clear) begin
            next_irq_enable = 1'h0;
        end
        if (take_irq_ret) begin
            next_irq_enable = 1'h1;
        end
    end

    // register the interrupt enable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            global_irq_enable <= `IRQ_ENABLE_RESET;
        end else begin
            global_irq_enable <= next_irq_enable;
        end
    end

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    // this block owns no status flags: neither the returns nor the idle
    // instruction touch them, so no status flag output exists here
endmodule : return_flow_instr_exec

// File: sim/rfx_chk_sva.sv
// checker for the return-flow executor
`timescale 1ns/1ns
module rfx_chk (
    input logic        clk_sys,
    input logic        rst,
    input logic        instr_valid,
    input logic        instr_ready,
    input logic        stack_pop,
    input logic        pc_load,
    input logic        global_irq_enable,
    input logic        instr_done,
    input logic [13:0] instr_word,
    input logic [12:0] stack_top_entry,
    input logic [12:0] pc,
    input logic [7:0]  acc
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // a word taken, and which return or idle it is
    wire       tk       = instr_valid && instr_ready;
    wire       irq      = tk && instr_word == 14'h0009;
    wire       lit      = tk && instr_word[13:10] == 4'hD;
    wire       ret      = tk && instr_word == 14'h0008;
    wire       idl      = tk && (instr_word & 14'h3F9F) == 14'h0000;
    wire [7:0] lit_byte = instr_word[7:0];
    // pop and load of the entry offered at the taking edge
    sequence s_pop;
        pc_load && stack_pop && pc == $past(stack_top_entry);
    endsequence
    // ready low in the flush cycle, completion one edge later
    sequence s_two;
        !instr_ready ##1 instr_done;
    endsequence
    property p_irq;
        irq |=> s_pop ##0 global_irq_enable ##0 s_two;
    endproperty
    a_irq: assert property (p_irq) else $error("irq return failed");
    property p_lit;
        lit |=> acc == $past(lit_byte);
    endproperty
    a_lit: assert property (p_lit) else $error("literal not loaded");
    property p_lpc;
        lit |=> s_pop;
    endproperty
    a_lpc: assert property (p_lpc) else $error("literal return pc not loaded");
    property p_ltw;
        lit |=> s_two;
    endproperty
    a_ltw: assert property (p_ltw) else $error("literal return not two cycles");
    property p_sub;
        ret |=> s_pop;
    endproperty
    a_sub: assert property (p_sub) else $error("return pc not loaded");
    property p_stw;
        ret |=> s_two;
    endproperty
    a_stw: assert property (p_stw) else $error("return not two cycles");
    property p_idl;
        idl |=> instr_done && !pc_load && !stack_pop && $stable(acc) && $stable(pc);
    endproperty
    a_idl: assert property (p_idl) else $error("idle changed state");
endmodule : rfx_chk

// File: sim/return_flow_instr_exec_bench.sv
// bench for the return-flow executor
`timescale 1ns/1ns
module return_flow_instr_exec_bench;
    logic        clk_sys          = 1'h0;
    logic        rst              = 1'h1;
    logic        instr_valid      = 1'h0;
    logic        irq_enable_clear = 1'h0;
    logic [13:0] instr_word       = 14'h0000;
    logic [12:0] stack_top_entry  = 13'h0000;
    logic [12:0] pc;
    logic [7:0]  acc;
    logic        instr_ready;
    logic        stack_pop;
    logic        pc_load;
    logic        global_irq_enable;
    logic        instr_done;
    logic        instr_unknown;
    int          bad_count;
    int          comparisons;
    // observed word: pc, acc, pop, ready, enable, done
    wire  [24:0] obs = {pc, acc, stack_pop, instr_ready, global_irq_enable, instr_done};
    always #20 clk_sys = ~clk_sys;
    return_flow_instr_exec return_flow_instr_exec_inst (
        .clk_sys           (clk_sys),
        .rst               (rst),
        .instr_valid       (instr_valid),
        .instr_word        (instr_word),
        .stack_top_entry   (stack_top_entry),
        .irq_enable_clear  (irq_enable_clear),
        .instr_ready       (instr_ready),
        .stack_pop         (stack_pop),
        .pc                (pc),
        .pc_load           (pc_load),
        .acc               (acc),
        .global_irq_enable (global_irq_enable),
        .instr_done        (instr_done),
        .instr_unknown     (instr_unknown)
    );
    // compare the observed word
    task chk(input logic [24:0] e);
        comparisons++;
        if (obs !== e) begin
            $display("[FAIL] obs expected %h seen %h", e, obs);
            bad_count++;
        end
    endtask : chk
    // compare one flag output
    task chk_bit(input string name, input logic e, input logic s);
        comparisons++;
        if (s !== e) begin
            $display("[FAIL] %s expected %b seen %b", name, e, s);
            bad_count++;
        end
    endtask : chk_bit
    // one instruction; a two-cycle one is checked again one cycle after its flush cycle, at completion
    task op(input logic [13:0] w, input logic [12:0] s, input logic [24:0] a, input logic two);
        @(negedge clk_sys);
        instr_valid = 1'h1;
        instr_word = w;
        stack_top_entry = s;
        @(negedge clk_sys);
        instr_valid = 1'h0;
        chk(a);
        chk_bit("pc_load", a[3], pc_load);
        chk_bit("instr_unknown", 1'h0, instr_unknown);
        if (two) begin
            @(negedge clk_sys);
            chk({a[24:4], 1'h0, 1'h1, a[1], 1'h1});
            chk_bit("pc_load", 1'h0, pc_load);
        end
    endtask : op
    task t_pop;
        op(14'h37AB, 13'h1ABC, 25'h1ABCAB8, 1'h1);
        op(14'h0009, 13'h1FFF, 25'h1FFFABA, 1'h1);
    endtask : t_pop
    task t_ret;
        op(14'h0008, 13'h0555, 25'h0555ABA, 1'h1);
        op(14'h0060, 13'h0AAA, 25'h0555AB7, 1'h0);
        op(14'h0020, 13'h0AAA, 25'h0555AB7, 1'h0);
    endtask : t_ret
    // enable cleared, then cleared and set in one cycle: the set wins
    task t_irq;
        @(negedge clk_sys);
        irq_enable_clear = 1'h1;
        @(negedge clk_sys);
        chk(25'h0555AB4);
        instr_valid = 1'h1;
        instr_word = 14'h0009;
        stack_top_entry = 13'h0123;
        @(negedge clk_sys);
        instr_valid = 1'h0;
        irq_enable_clear = 1'h0;
        chk(25'h0123ABA);
    endtask : t_irq
    // a foreign opcode is flagged, and refused during a flush cycle
    task t_unk;
        @(negedge clk_sys);
        instr_valid = 1'h1;
        instr_word = 14'h0064;
        @(negedge clk_sys);
        chk_bit("instr_unknown", 1'h1, instr_unknown);
        chk(25'h0123AB6);
        instr_word = 14'h0008;
        stack_top_entry = 13'h0321;
        @(negedge clk_sys);
        chk(25'h0321ABA);
        instr_word = 14'h0064;
        @(negedge clk_sys);
        instr_valid = 1'h0;
        chk_bit("instr_unknown", 1'h0, instr_unknown);
        chk(25'h0321AB7);
    endtask : t_unk
    // reset in the middle of a literal return, then work resumes
    task t_rst;
        @(negedge clk_sys);
        instr_valid = 1'h1;
        instr_word = 14'h3455;
        stack_top_entry = 13'h0042;
        @(negedge clk_sys);
        instr_valid = 1'h0;
        chk(25'h004255A);
        rst = 1'h1;
        @(negedge clk_sys);
        rst = 1'h0;
        chk(25'h0000004);
        chk_bit("pc_load", 1'h0, pc_load);
        chk_bit("instr_unknown", 1'h0, instr_unknown);
        op(14'h0000, 13'h0000, 25'h0000005, 1'h0);
    endtask : t_rst
    task summarize;
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (12) @(negedge clk_sys);
        rst = 1'h0;
        t_pop;
        t_ret;
        t_irq;
        t_unk;
        t_rst;
        summarize;
    end
endmodule : return_flow_instr_exec_bench
bind return_flow_instr_exec rfx_chk rfx_chk_inst (
    .clk_sys           (clk_sys),
    .rst               (rst),
    .instr_valid       (instr_valid),
    .instr_ready       (instr_ready),
    .stack_pop         (stack_pop),
    .pc_load           (pc_load),
    .global_irq_enable (global_irq_enable),
    .instr_done        (instr_done),
    .instr_word        (instr_word),
    .stack_top_entry   (stack_top_entry),
    .pc                (pc),
    .acc               (acc)
);
